//--- hw/irqc_top.sv
// irqc_top.sv: interrupt priority, enables, pending flags, external edges
// assumes: core register port with one-cycle write and byte/bit strobes,
// peripheral request levels on the same clock, gpio pins asynchronous
// Contract
// RULE_01: main priority bit 7 reads one
// RULE_02: main priority bits map seven sources
// RULE_03: main priority at 0xB8, bit access
// RULE_04: extended enable gates three sources
// RULE_05: bits 7..5 read zero, ignore writes
// RULE_06: software keeps extended bits 1..0 zero
// RULE_07: extended priority for three sources
// RULE_08: soft flags set only by software
// RULE_09: serializer empty sets flag, sticky
// RULE_10: software clears serializer flag before write
// RULE_11: edges set external flags regardless enable
// RULE_12: hardware never clears external flags
// RULE_13: external sources edge sensitive only
// RULE_14: rising, falling or both edges
// RULE_15: pins sampled by system clock
// RULE_16: pin chosen by port config fields
// RULE_17: edge events also feed timer captures
// RULE_18: decode every cycle, four-cycle call
// RULE_19: master gate blocks all sources
// RULE_20: code 101 selects GPIO8 or GPIO9
// RULE_21: polarity bit inverts selected pin
// RULE_22: high preempts low, lower vector wins
// RULE_23: previous sample compared for edges
`timescale 1ns/1ps
`include "irqc_defs.svh"
module irqc_top
  import irqc_pkg::*;
(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // register port from the core
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_BIT_WR,
  input  wire logic [2:0]  REG_BIT_SEL,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  // core handshake
  input  wire logic        IRQ_RETURN,
  output logic             IRQ_REQ,
  output logic      [3:0]  IRQ_VECTOR,
  // peripheral requests: tmr2 dmd rtc tmr3 fc, serializer empty
  input  wire logic        TMR2_REQ,
  input  wire logic        DMD_REQ,
  input  wire logic        RTC_REQ,
  input  wire logic        TMR3_REQ,
  input  wire logic        FC_REQ,
  input  wire logic        SER_EMPTY,
  // gpio pins
  input  wire logic [9:0]  GPIO_IN,
  // capture triggers
  output logic             TMR2_CAPTURE,
  output logic             TMR3_CAPTURE
);
  irqc_edge_if eif ();
  logic [7:0] prio_main, next_prio_main;
  logic [7:0] en_main, next_en_main;
  logic [7:0] en_ext, next_en_ext;
  logic [7:0] prio_ext, next_prio_ext;
  logic [7:0] pend, next_pend;
  logic [7:0] port_cfg, next_port_cfg;
  logic [1:0] edge_cfg, next_edge_cfg;
  logic [9:0] gpio_s1, gpio_s2;
  logic       ser_prev;
  logic [7:0] rdata, next_rdata;
  irqc_state_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [3:0] cur_vec, next_cur_vec;
  logic       cur_hi, next_cur_hi;
  logic       low_act, next_low_act;
  logic       req, next_req;
  logic [3:0] vec_o, next_vec_o;
  logic [1:0] cap, next_cap;
  logic [11:0] src_req, src_en, src_hi;
  logic [3:0] win_vec;
  logic       win_any;
  logic       win_hi;
  logic       wr_hit;
  logic [7:0] wval;

  assign eif.gpio_sync = gpio_s2;
  assign eif.port_cfg  = port_cfg;
  assign eif.dual_edge = edge_cfg;
  irqc_edge_det u_det (
    .REF_CLK (REF_CLK),
    .RST     (RST),
    .e       (eif)
  );

  // RULE_15 two-flop pin sampling
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      gpio_s1 <= 10'h000;
      gpio_s2 <= 10'h000;
    end
    else
    begin
      gpio_s1 <= GPIO_IN;
      gpio_s2 <= gpio_s1;
    end
  end

  // byte write or single-bit set/clear merged into one value
  function automatic logic [7:0] merge(input logic [7:0] old);
    logic [7:0] v;
    v = old;
    if (REG_BIT_WR)
      v[REG_BIT_SEL] = REG_WDATA[0];
    else
      v = REG_WDATA;
    return v;
  endfunction

  assign wr_hit = REG_WR | REG_BIT_WR;

  always_comb
  begin
    next_prio_main = prio_main;
    next_en_main   = en_main;
    next_en_ext    = en_ext;
    next_prio_ext  = prio_ext;
    next_port_cfg  = port_cfg;
    next_edge_cfg  = edge_cfg;
    next_pend      = pend;
    wval           = 8'h00;
    if (wr_hit)
    begin
      if (REG_ADDR == `IRQC_ADDR_PRIO_MAIN)
      begin
        // RULE_03 bit and byte access
        wval = merge(prio_main);
        // RULE_01 top bit fixed
        // RULE_02 seven priority bits
        next_prio_main = wval | `IRQC_PRIO_MAIN_FIXED;
      end
      else if (REG_ADDR == `IRQC_ADDR_IRQ_ENABLE)
        next_en_main = merge(en_main);
      else if (REG_ADDR == `IRQC_ADDR_ENABLE_EXT)
      begin
        // RULE_04 enable bits
        // RULE_05 upper bits dropped
        // RULE_06 low bits kept zero
        wval = merge(en_ext);
        next_en_ext = wval & `IRQC_EXT_MASK;
      end
      else if (REG_ADDR == `IRQC_ADDR_PRIO_EXT)
      begin
        // RULE_07 extended priority
        wval = merge(prio_ext);
        next_prio_ext = wval & `IRQC_EXT_MASK;
      end
      else if (REG_ADDR == `IRQC_ADDR_PENDING)
      begin
        wval = merge(pend);
        next_pend = wval & `IRQC_PEND_MASK;
      end
      else if (REG_ADDR == `IRQC_ADDR_PORT_CFG)
        next_port_cfg = merge(port_cfg);
      else if (REG_ADDR == `IRQC_ADDR_EDGE_CFG)
        next_edge_cfg = 2'(merge({6'h00, edge_cfg}));
    end
    // set beats clear in the same cycle
    // RULE_09 serializer empty edge
    // RULE_10 clear must precede refill
    if (SER_EMPTY & ~ser_prev)
      next_pend[`IRQC_PEND_SER] = 1'b1;
    // RULE_11 edge sets flag regardless of enable
    // RULE_12 only software clears
    next_pend[1:0] = next_pend[1:0] | eif.edge_evt;
  end

  // source tables, index is vector order
  always_comb
  begin
    src_req = {pend[`IRQC_PEND_SOFT1], pend[`IRQC_PEND_SOFT0], FC_REQ,
               2'b00, pend[`IRQC_PEND_EXT_B], TMR3_REQ,
               pend[`IRQC_PEND_SER], RTC_REQ, DMD_REQ, TMR2_REQ,
               pend[`IRQC_PEND_EXT_A]};
    // RULE_08 soft flags raise requests
    src_en = {en_ext[4:2], 2'b00, en_main[6:0]};
    src_hi = {prio_ext[4:2], 2'b00, prio_main[6:0]};
  end

  // RULE_19 master gate
  // RULE_22 fixed order, high first
  always_comb
  begin
    logic [11:0] act;
    logic [11:0] hi_act;
    act     = en_main[`IRQC_GATE_BIT] ? (src_req & src_en) : 12'h000;
    hi_act  = act & src_hi;
    win_vec = 4'h0;
    win_any = 1'b0;
    win_hi  = 1'b0;
    for (int i = `IRQC_NUM_SRC - 1; i >= 0; i--)
    begin
      if (act[i] & ~(|hi_act))
      begin
        win_vec = 4'(i);
        win_any = 1'b1;
      end
      if (hi_act[i])
      begin
        win_vec = 4'(i);
        win_any = 1'b1;
        win_hi  = 1'b1;
      end
    end
  end

  // RULE_18 decode every cycle, four-cycle call
  always_comb
  begin
    next_state   = state;
    next_cnt     = cnt;
    next_cur_vec = cur_vec;
    next_cur_hi  = cur_hi;
    next_low_act = low_act;
    next_req     = 1'b0;
    next_vec_o   = vec_o;
    case (state)
      IRQC_IDLE:
      begin
        if (win_any)
        begin
          next_state   = IRQC_CALL;
          next_cnt     = 3'(`IRQC_CALL_CYCLES - 1);
          next_cur_vec = win_vec;
          next_cur_hi  = win_hi;
          next_req     = 1'b1;
          next_vec_o   = win_vec;
        end
      end
      IRQC_CALL:
      begin
        if (cnt == 3'h0)
          next_state = IRQC_SERV;
        else
          next_cnt = cnt - 3'h1;
      end
      default:
      begin
        if (IRQ_RETURN)
        begin
          next_state   = low_act & cur_hi ? IRQC_SERV : IRQC_IDLE;
          next_cur_hi  = 1'b0;
          next_low_act = cur_hi ? low_act : 1'b0;
        end
        else if (~cur_hi & win_any & win_hi)
        begin
          // RULE_22 preempt low handler
          next_state   = IRQC_CALL;
          next_cnt     = 3'(`IRQC_CALL_CYCLES - 1);
          next_low_act = 1'b1;
          next_cur_vec = win_vec;
          next_cur_hi  = 1'b1;
          next_req     = 1'b1;
          next_vec_o   = win_vec;
        end
      end
    endcase
  end

  always_comb
  begin
    next_rdata = 8'h00;
    if (REG_ADDR == `IRQC_ADDR_PRIO_MAIN)
      next_rdata = prio_main;
    else if (REG_ADDR == `IRQC_ADDR_IRQ_ENABLE)
      next_rdata = en_main;
    else if (REG_ADDR == `IRQC_ADDR_ENABLE_EXT)
      next_rdata = en_ext;
    else if (REG_ADDR == `IRQC_ADDR_PRIO_EXT)
      next_rdata = prio_ext;
    else if (REG_ADDR == `IRQC_ADDR_PENDING)
      next_rdata = pend;
    else if (REG_ADDR == `IRQC_ADDR_PORT_CFG)
      next_rdata = port_cfg;
    else if (REG_ADDR == `IRQC_ADDR_EDGE_CFG)
      next_rdata = {6'h00, edge_cfg};
    // RULE_17 capture triggers
    next_cap = {eif.edge_evt[1], eif.edge_evt[0]};
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      prio_main <= `IRQC_PRIO_MAIN_RST;
      en_main   <= 8'h00;
      en_ext    <= 8'h00;
      prio_ext  <= 8'h00;
      pend      <= 8'h00;
      port_cfg  <= 8'h00;
      edge_cfg  <= 2'h0;
      ser_prev  <= 1'b1; // no false edge if already empty
      rdata     <= 8'h00;
      state     <= IRQC_IDLE;
      cnt       <= 3'h0;
      cur_vec   <= 4'h0;
      cur_hi    <= 1'b0;
      low_act   <= 1'b0;
      req       <= 1'b0;
      vec_o     <= 4'h0;
      cap       <= 2'h0;
    end
    else
    begin
      prio_main <= next_prio_main;
      en_main   <= next_en_main;
      en_ext    <= next_en_ext;
      prio_ext  <= next_prio_ext;
      pend      <= next_pend;
      port_cfg  <= next_port_cfg;
      edge_cfg  <= next_edge_cfg;
      ser_prev  <= SER_EMPTY;
      rdata     <= next_rdata;
      state     <= next_state;
      cnt       <= next_cnt;
      cur_vec   <= next_cur_vec;
      cur_hi    <= next_cur_hi;
      low_act   <= next_low_act;
      req       <= next_req;
      vec_o     <= next_vec_o;
      cap       <= next_cap;
    end
  end

  assign REG_RDATA    = rdata;
  assign IRQ_REQ      = req;
  assign IRQ_VECTOR   = vec_o;
  assign TMR3_CAPTURE = cap[1];
  assign TMR2_CAPTURE = cap[0];

  default clocking a_clk @(posedge REF_CLK); endclocking
  default disable iff (RST);
  top_bit_one_a: assert property (prio_main[7]) // RULE_01
    else $error("priority top bit low");
  ext_upper_zero_a: assert property ( // RULE_05
    {en_ext[7:5], prio_ext[7:5], pend[7:5]} == 9'h000)
    else $error("reserved bits set");
  ext_low_zero_a: assert property ( // RULE_06
    {en_ext[1:0], prio_ext[1:0]} == 4'h0)
    else $error("extended low bits set");
  edge_sets_flag_a: assert property (eif.edge_evt[0] |=> pend[0]) // RULE_11
    else $error("edge a lost");
  ser_sets_flag_a: assert property ( // RULE_09
    SER_EMPTY && !ser_prev |=> pend[2])
    else $error("serializer flag lost");
  ext_flag_hold_a: assert property (pend[1] && !wr_hit |=> pend[1]) // RULE_12
    else $error("ext b flag cleared");
  gate_blocks_a: assert property ( // RULE_19
    !en_main[7] && state == IRQC_IDLE |=> !req)
    else $error("request with gate off");
  call_len_a: assert property ( // RULE_18
    req |-> state == IRQC_CALL ##4 state == IRQC_SERV)
    else $error("call length wrong");
  capture_follow_a: assert property ( // RULE_17
    eif.edge_evt[1] |=> TMR3_CAPTURE)
    else $error("capture b missing");
  preempt_cov: cover property (low_act && req);
  ext_irq_cov: cover property (req && vec_o == 4'h0);
  soft_irq_cov: cover property (req && vec_o == 4'hB);
endmodule

//--- hw/irqc_defs.svh
// irqc_defs.svh: offsets, field positions, reset values and timing counts
// assumes: included by the interrupt block files only
`ifndef IRQC_DEFS_SVH
`define IRQC_DEFS_SVH
`define IRQC_ADDR_PRIO_MAIN    8'hB8
`define IRQC_ADDR_PENDING      8'hBF
`define IRQC_ADDR_ENABLE_EXT   8'hE6
`define IRQC_ADDR_PRIO_EXT     8'hF6
`define IRQC_ADDR_IRQ_ENABLE   8'hA8
`define IRQC_ADDR_PORT_CFG     8'hB7
`define IRQC_ADDR_EDGE_CFG     8'hB6
`define IRQC_PRIO_MAIN_RST     8'h80
`define IRQC_PRIO_MAIN_FIXED   8'h80
`define IRQC_EXT_MASK          8'h1C
`define IRQC_PEND_MASK         8'h1F
`define IRQC_PEND_EXT_A        0
`define IRQC_PEND_EXT_B        1
`define IRQC_PEND_SER          2
`define IRQC_PEND_SOFT0        3
`define IRQC_PEND_SOFT1        4
`define IRQC_GATE_BIT          7
`define IRQC_NUM_SRC           12
`define IRQC_CALL_CYCLES       4
`endif

//--- hw/irqc_pkg.sv
// irqc_pkg.sv: shared types of the interrupt block
// assumes: nothing beyond the defs header
package irqc_pkg;
  typedef enum logic [1:0]
  {
    IRQC_IDLE = 2'b00,
    IRQC_CALL = 2'b01,
    IRQC_SERV = 2'b10
  } irqc_state_t;
  typedef logic [3:0] irqc_vec_t;
endpackage

//--- hw/irqc_edge_if.sv
// irqc_edge_if.sv: signals between the top and the edge detector
// assumes: one clock, one detector pair
`timescale 1ns/1ps
interface irqc_edge_if;
  logic [9:0] gpio_sync;
  logic [7:0] port_cfg;
  logic [1:0] dual_edge;
  logic [1:0] edge_evt;
  modport top (output gpio_sync, output port_cfg, output dual_edge,
               input edge_evt);
  modport det (input gpio_sync, input port_cfg, input dual_edge,
               output edge_evt);
endinterface

//--- hw/irqc_edge_det.sv
// irqc_edge_det.sv: pin select, polarity and edge detection for two sources
// assumes: gpio already passed two flip-flops in the top
`timescale 1ns/1ps
`include "irqc_defs.svh"
module irqc_edge_det
  import irqc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // link to top
  irqc_edge_if.det e
);
  logic [1:0] prev;
  logic [1:0] next_prev;
  logic [1:0] cur;
  logic [1:0] evt;
  logic [1:0] next_evt;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_src
      logic [2:0] sel;
      logic       raw;
      assign sel = e.port_cfg[g*4 +: 3];
      // RULE_16 pin select
      // RULE_20 code 101 picks GPIO8 or GPIO9
      assign raw = (sel == 3'h5) ? e.gpio_sync[8 + g] : e.gpio_sync[sel];
      // RULE_21 optional inversion
      assign cur[g] = raw ^ e.port_cfg[g*4 + 3];
    end
  endgenerate
  always_comb
  begin
    next_prev = cur;
    // RULE_23 compare with previous sample
    // RULE_13 edges only; RULE_14 rising or both
    next_evt = (cur & ~prev) | (e.dual_edge & (cur ^ prev));
  end
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      prev <= 2'h0;
      evt  <= 2'h0;
    end
    else
    begin
      prev <= next_prev;
      evt  <= next_evt;
    end
  end
  assign e.edge_evt = evt;
endmodule

//--- dv/irqc_core_model.sv
// irqc_core_model.sv: core side of the handler call and return handshake
// assumes: IRQ_REQ is a one-cycle pulse on REF_CLK
`timescale 1ns/1ps
module irqc_core_model
(
  // clock and reset
  input  wire logic REF_CLK,
  input  wire logic RST,
  // handshake
  input  wire logic IRQ_REQ,
  input  wire logic SLOW,
  output logic      IRQ_RETURN
);
  int cnt;
  initial IRQ_RETURN = 1'b0;
  // return after call
  // never touches pending flags; return only after the four call cycles
  always @(posedge REF_CLK)
  begin
    IRQ_RETURN <= !RST && !IRQ_REQ && cnt == 1;
    if (RST)
      cnt <= 0;
    else if (IRQ_REQ)
      cnt <= SLOW ? 30 : 6;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule

//--- dv/irqc_top_test.sv
// irqc_top_test.sv: self-checking bench of the interrupt block
// assumes: core model answers calls; peripheral requests driven by scenarios
`timescale 1ns/1ps
module irqc_top_test;
  import irqc_pkg::*;
  logic       clk, rst, wr_s, bwr_s, ret, tmr2, ser, slow, req, cap_a, cap_b;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] bsel;
  logic [9:0] gpio;
  logic [3:0] vec, preq;
  int         bad_count, total_checks, ncap_a, ncap_b, n;

  irqc_top u_irqc_top (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr),
    .REG_WR(wr_s), .REG_BIT_WR(bwr_s), .REG_BIT_SEL(bsel),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .IRQ_RETURN(ret),
    .IRQ_REQ(req), .IRQ_VECTOR(vec), .TMR2_REQ(tmr2), .DMD_REQ(preq[0]),
    .RTC_REQ(preq[1]), .TMR3_REQ(preq[2]), .FC_REQ(preq[3]), .SER_EMPTY(ser),
    .GPIO_IN(gpio), .TMR2_CAPTURE(cap_a), .TMR3_CAPTURE(cap_b));
  irqc_core_model u_irqc_core_model (.REF_CLK(clk), .RST(rst),
    .IRQ_REQ(req), .SLOW(slow), .IRQ_RETURN(ret));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (cap_a === 1'b1) ncap_a++;
    if (cap_b === 1'b1) ncap_b++;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic bwr(input logic [7:0] a, input logic [2:0] b, input logic v);
    @(posedge clk);
    addr <= a;
    bsel <= b;
    wdata <= {7'h00, v};
    bwr_s <= 1'b1;
    @(posedge clk);
    bwr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    idle(2);
    #1;
    chk(rdata, exp);
  endtask
  // waits a bounded window for a call and checks its vector
  task automatic wreq(input logic want, input logic [3:0] v);
    logic seen;
    seen = 1'b0;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      if (req === 1'b1 && !seen)
      begin
        seen = 1'b1;
        chk({4'h0, vec}, {4'h0, v});
      end
    end
    chk({7'h00, seen}, {7'h00, want});
    if (want && !seen)
      complete_run();
  endtask

  task automatic s_reset();
    rd(8'hB8, 8'h80);
    rd(8'hBF, 8'h00);
    rd(8'hE6, 8'h00);
    rd(8'hF6, 8'h00);
    rd(8'h55, 8'h00);
  endtask
  task automatic s_prio();
    wr(8'hB8, 8'h00);
    rd(8'hB8, 8'h80);
    wr(8'hB8, 8'h7F);
    rd(8'hB8, 8'hFF);
    bwr(8'hB8, 3'h7, 1'b0);
    bwr(8'hB8, 3'h0, 1'b0);
    rd(8'hB8, 8'hFE);
    wr(8'hB8, 8'h00);
  endtask
  // upper reserved bits written as ones, low pair left at zero
  task automatic s_ext_regs();
    wr(8'hE6, 8'hFC);
    rd(8'hE6, 8'h1C);
    wr(8'hF6, 8'hFC);
    rd(8'hF6, 8'h1C);
    wr(8'hE6, 8'h00);
    wr(8'hF6, 8'h00);
    wr(8'hBF, 8'hE0);
    rd(8'hBF, 8'h00);
    wr(8'hBF, 8'h18);
    rd(8'hBF, 8'h18);
    wr(8'hBF, 8'h00);
  endtask
  // table: invert, dual, level before, expected flag; GPIO5 toggles too
  task automatic s_edges();
    logic [4:0] inv_t, dual_t, from_t, exp_t;
    inv_t = 5'b01100;
    dual_t = 5'b10000;
    from_t = 5'b10110;
    exp_t = 5'b10101;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      gpio[8] <= from_t[i];
      wr(8'hB7, {4'h0, inv_t[i], 3'b101});
      wr(8'hB6, {7'h00, dual_t[i]});
      idle(8);
      wr(8'hBF, 8'h00);
      n = ncap_a;
      @(posedge clk);
      gpio[8] <= ~from_t[i];
      gpio[5] <= ~gpio[5];
      idle(8);
      rd(8'hBF, {7'h00, exp_t[i]});
      chk(8'(ncap_a - n), {7'h00, exp_t[i]});
      wr(8'hBF, 8'h00);
      idle(8);
      rd(8'hBF, 8'h00);
    end
    wr(8'hB7, 8'h50);
    wr(8'hB6, 8'h00);
    idle(8);
    wr(8'hBF, 8'h00);
    n = ncap_b;
    @(posedge clk);
    gpio[9] <= ~gpio[9];
    idle(8);
    rd(8'hBF, 8'h02);
    chk(8'(ncap_b - n), 8'h01);
    wr(8'hBF, 8'h00);
  endtask
  task automatic s_ser();
    @(posedge clk);
    ser <= 1'b1;
    idle(6);
    @(posedge clk);
    ser <= 1'b0;
    idle(6);
    rd(8'hBF, 8'h04);
    wr(8'hBF, 8'h00);
    rd(8'hBF, 8'h00);
  endtask
  task automatic s_irq();
    @(posedge clk);
    tmr2 <= 1'b1;
    wr(8'hA8, 8'h02);
    wreq(1'b0, 4'h0);
    wr(8'hA8, 8'h82);
    wreq(1'b1, 4'h1);
    wr(8'hA8, 8'h00);
    idle(40);
    wr(8'hE6, 8'h08);
    wr(8'hBF, 8'h08);
    wr(8'hF6, 8'h08);
    wr(8'hA8, 8'h82);
    wreq(1'b1, 4'hA);
    wr(8'hA8, 8'h00);
    idle(40);
    wr(8'hF6, 8'h00);
    wr(8'hA8, 8'h82);
    wreq(1'b1, 4'h1);
    wr(8'hA8, 8'h00);
    @(posedge clk);
    tmr2 <= 1'b0;
    slow <= 1'b1;
    wr(8'hBF, 8'h00);
    wr(8'hE6, 8'h00);
    wr(8'hB7, 8'h03);
    idle(40);
    @(posedge clk);
    gpio[3] <= ~gpio[3];
    wr(8'hB6, 8'h01);
    wr(8'hA8, 8'h81);
    wreq(1'b1, 4'h0);
    wr(8'hA8, 8'h00);
    idle(40);
    rd(8'hBF, 8'h01);
  endtask
  // each of the dmd, rtc, tmr3 and fc requests alone reaches its own vector
  task automatic s_map();
    logic [15:0] vec_t;
    logic [31:0] en_t;
    vec_t = 16'h9532;
    en_t = 32'h80A08884;
    wr(8'hE6, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      preq <= 4'(1 << i);
      wr(8'hA8, en_t[i*8 +: 8]);
      wreq(1'b1, vec_t[i*4 +: 4]);
      wr(8'hA8, 8'h00);
      idle(40);
    end
    @(posedge clk);
    preq <= 4'h0;
    wr(8'hE6, 8'h00);
  endtask

  initial
  begin
    rst = 1'b1;
    {wr_s, bwr_s, tmr2, ser, slow} = 5'h00;
    {addr, wdata, bsel, gpio} = 29'h0;
    preq = 4'h0;
    bad_count = 0;
    total_checks = 0;
    ncap_a = 0;
    ncap_b = 0;
    idle(6);
    rst <= 1'b0;
    s_reset();
    s_prio();
    s_ext_regs();
    s_edges();
    s_ser();
    s_irq();
    s_map();
    complete_run();
  end
endmodule
